// file: logic/tw_defs.svh
/*
 constants of the two-wire bus engine: timing, packet layout.
 assumes: included by bare name from logic/ files.
*/
`ifndef TW_DEFS_SVH
`define TW_DEFS_SVH
`define TW_SYS_MHZ 25
`define TW_THALF_NS 5000
`define TW_THALF_CYC ((`TW_THALF_NS * `TW_SYS_MHZ + 999) / 1000)
`define TW_ACK_IDX 4'h8
`define TW_TX_LAST 4'h7
`define TW_RW_BIT 0
`define TW_TMR_ONE 16'h0001
`define TW_TMR_ZERO 16'h0000
`endif

// file: logic/tw_pkg.sv
/*
 types shared by the two-wire bus engine: commands and state sets.
 assumes: compiled before every other logic/ file.
*/
`default_nettype none
package tw_pkg;
	typedef enum logic [1:0] {TW_CMD_START, TW_CMD_DATA, TW_CMD_STOP} tw_cmd_e;
	typedef enum logic [3:0] {M_IDLE, M_START, M_LOW, M_HIGH, M_HOLD, M_RS_A, M_RS_B,
		M_ST_A, M_ST_B, M_ST_C, M_LOST} tw_mst_e;
	typedef enum logic [2:0] {S_IDLE, S_RX, S_WAIT, S_ACK, S_TX, S_MACK} tw_slv_e;
endpackage
`default_nettype wire

// file: logic/tw_sync.sv
/*
 two-flop level synchroniser, parameterised width.
 assumes: input is a level from another clock or a pin; no reset needed.
*/
`timescale 1ns/1ps
`default_nettype none
module tw_sync #(
	parameter int W = 1
) (
	// clock
	input wire logic clk,
	// data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stab;
	} tw_sync_s;
	tw_sync_s s_q;
	tw_sync_s s_d;

	// first stage feeds only the second
	always_comb begin
		s_d.meta = d;
		s_d.stab = s_q.meta;
	end

	always_ff @(posedge clk) begin
		s_q <= s_d;
	end

	assign q = s_q.stab;
endmodule // tw_sync
`default_nettype wire

// file: logic/tw_link.sv
/*
 link-side front end: samples the bus pins, spots start and stop,
 and drives the open-drain enables.
 assumes: link_clk free running; link_rst synchronous to link_clk;
 drive levels arrive from the system clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module tw_link (
	// clock and reset
	input wire logic link_clk,
	input wire logic link_rst,
	// bus pins
	input wire logic scl_i,
	input wire logic sda_i,
	output logic scl_oe,
	output logic sda_oe,
	// drive requests from system domain
	input wire logic scl_low,
	input wire logic sda_low,
	// towards system domain
	output logic scl_lv,
	output logic sda_lv,
	output logic start_tgl,
	output logic stop_tgl
);
	typedef struct packed {
		logic scl1;
		logic scl2;
		logic sda1;
		logic sda2;
		logic scl_p;
		logic sda_p;
		logic st_t;
		logic sp_t;
		logic [1:0] dr1;
		logic [1:0] dr2;
		logic scl_oe;
		logic sda_oe;
	} tw_link_s;
	tw_link_s q;
	tw_link_s d;

	// pin sampling, condition detection, drive crossing
	always_comb begin
		d = q;
		d.scl1 = scl_i;
		d.scl2 = q.scl1; // R23
		d.sda1 = sda_i;
		d.sda2 = q.sda1; // R23
		d.scl_p = q.scl2;
		d.sda_p = q.sda2;
		// falling data while clock stays high
		if (q.sda_p & ~q.sda2 & q.scl2 & q.scl_p) begin
			d.st_t = ~q.st_t; // R01
		end
		// rising data while clock stays high
		if (~q.sda_p & q.sda2 & q.scl2 & q.scl_p) begin
			d.sp_t = ~q.sp_t; // R02
		end
		d.dr1 = {scl_low, sda_low};
		d.dr2 = q.dr1;
		d.scl_oe = q.dr2[1];
		d.sda_oe = q.dr2[0];
	end

	always_ff @(posedge link_clk) begin
		if (link_rst) begin
			q <= '0;
			// pin mirrors start at the pulled-up idle level, so no false start or stop
			q.scl1 <= 1'b1;
			q.scl2 <= 1'b1;
			q.sda1 <= 1'b1;
			q.sda2 <= 1'b1;
			q.scl_p <= 1'b1;
			q.sda_p <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign scl_oe = q.scl_oe;
	assign sda_oe = q.sda_oe;
	assign scl_lv = q.scl2;
	assign sda_lv = q.sda2;
	assign start_tgl = q.st_t;
	assign stop_tgl = q.sp_t;
endmodule // tw_link
`default_nettype wire

// file: logic/tw_engine.sv
/*
 two-wire bus protocol engine: master byte engine with arbitration,
 clock stretching and start/stop generation, plus a 7-bit slave.
 assumes: sys_clk at 25 MHz, rst synchronous active high, link_clk
 free running, pull-ups on both lines outside.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tw_defs.svh"

// Summary of operation
// R01 - start is data falling, clock high
// R02 - stop is data rising, clock high
// R03 - start without stop is repeated start
// R04 - data changes only while clock low
// R05 - eight bits msb first, then ack
// R06 - ack low in ninth clock, nack high
// R07 - after start, address and direction bit
// R08 - matching slave acks, others wait start
// R09 - one address packet per start
// R10 - direction bit selects write or read
// R11 - data packets follow address direction
// R12 - write without data: stop after address
// R13 - nacked write data ends transaction
// R14 - read continues only after address ack
// R15 - master acks reads, nacks last byte
// R16 - stretch only after clock seen low
// R17 - slave stretches only around ack bit
// R18 - wait while the other stretches clock
// R19 - master starts only on idle bus
// R20 - lose bus when high reads low
// R21 - after loss wait for stop, idle
// R22 - no start/stop versus data arbitration
// R23 - synchronise pins before any detection
module tw_engine
	import tw_pkg::*;
#(
	parameter logic [15:0] HALF_CYC = 16'(`TW_THALF_CYC)
) (
	// clocks and reset
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic link_clk,
	// bus pins
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	// master commands
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire tw_cmd_e cmd_kind,
	input wire logic [7:0] cmd_data,
	input wire logic cmd_ack,
	// master answers
	output logic rsp_valid,
	output logic [7:0] rsp_data,
	output logic rsp_nack,
	output logic arb_lost,
	output logic bus_busy,
	output logic mst_active,
	// slave side
	input wire logic slv_en,
	input wire logic [6:0] slv_addr,
	output logic slv_evt,
	output logic slv_is_addr,
	output logic slv_rw,
	output logic [7:0] slv_data,
	input wire logic slv_go,
	input wire logic slv_ack,
	input wire logic [7:0] slv_tx_data
);
	typedef struct packed {
		logic scl_p;
		logic start_p;
		logic stop_p;
		logic busy;
		tw_mst_e mst;
		logic [15:0] tmr;
		logic [3:0] cnt;
		logic [7:0] sh;
		logic rw;
		logic apkt;
		logic nack;
		logic mack;
		logic seen;
		logic m_scl;
		logic m_sda;
		logic rsp_v;
		logic [7:0] rsp_d;
		logic rsp_n;
		logic lost;
		tw_slv_e slv;
		logic [3:0] scnt;
		logic [7:0] ssh;
		logic sapkt;
		logic srw;
		logic sack;
		logic s_scl;
		logic s_sda;
		logic sevt;
		logic [7:0] sdat;
		logic sis_addr;
	} tw_eng_s;
	tw_eng_s q;
	tw_eng_s d;

	// ****************************************
	// link domain and crossings
	// ****************************************
	logic link_rst;
	logic scl_lv;
	logic sda_lv;
	logic start_tgl;
	logic stop_tgl;
	logic scl_s;
	logic sda_s;
	logic start_t;
	logic stop_t;

	tw_sync #(.W(1)) u_rst_sync (
		.clk(link_clk),
		.d(rst),
		.q(link_rst)
	);

	tw_link u_link (
		.link_clk(link_clk),
		.link_rst(link_rst),
		.scl_i(scl_i),
		.sda_i(sda_i),
		.scl_oe(scl_oe),
		.sda_oe(sda_oe),
		.scl_low(q.m_scl | q.s_scl),
		.sda_low(q.m_sda | q.s_sda),
		.scl_lv(scl_lv),
		.sda_lv(sda_lv),
		.start_tgl(start_tgl),
		.stop_tgl(stop_tgl)
	);

	// levels and event toggles into the system domain
	tw_sync #(.W(4)) u_bus_sync (
		.clk(sys_clk),
		.d({scl_lv, sda_lv, start_tgl, stop_tgl}),
		.q({scl_s, sda_s, start_t, stop_t})
	);

	assign scl_o = 1'b0;
	assign sda_o = 1'b0;

	// ****************************************
	// decoded events
	// ****************************************
	logic scl_rise;
	logic scl_fall;
	logic start_ev;
	logic stop_ev;
	logic tdone;
	logic sending;
	logic cmd_take;

	assign scl_rise = scl_s & ~q.scl_p;
	assign scl_fall = ~scl_s & q.scl_p;
	assign start_ev = start_t ^ q.start_p;
	assign stop_ev = stop_t ^ q.stop_p;
	assign tdone = (q.tmr == `TW_TMR_ZERO);
	assign sending = q.apkt | ~q.rw; // R10
	// idle bus needed for a fresh start
	assign cmd_ready = ((q.mst == M_IDLE) & ~q.busy & (cmd_kind == TW_CMD_START)) | (q.mst == M_HOLD); // R19
	assign cmd_take = cmd_valid & cmd_ready;

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		d = q;
		d.scl_p = scl_s;
		d.start_p = start_t;
		d.stop_p = stop_t;
		d.rsp_v = 1'b0;
		d.sevt = 1'b0;
		if (!tdone) begin
			d.tmr = q.tmr - `TW_TMR_ONE;
		end
		// bus busy from start to stop
		if (stop_ev) begin
			d.busy = 1'b0; // R02
		end else if (start_ev) begin
			d.busy = 1'b1; // R01
		end

		// master sequencer
		case (q.mst)
			M_IDLE: begin
				d.m_scl = 1'b0;
				d.m_sda = 1'b0;
				if (cmd_take) begin
					d.sh = cmd_data; // R07
					d.rw = cmd_data[`TW_RW_BIT];
					d.apkt = 1'b1;
					d.nack = 1'b0;
					d.lost = 1'b0;
					d.m_sda = 1'b1; // R01
					d.tmr = HALF_CYC;
					d.mst = M_START;
				end
			end
			M_START: begin
				if (tdone) begin
					d.cnt = 4'h0;
					d.seen = 1'b0;
					d.m_scl = 1'b1;
					d.mst = M_LOW;
				end
			end
			M_LOW: begin
				if (!q.seen) begin
					// move data only once the clock is seen low
					if (!scl_s) begin
						d.seen = 1'b1;
						d.tmr = HALF_CYC;
						if (q.cnt == `TW_ACK_IDX) begin
							d.m_sda = ~sending & q.mack; // R06 R15
						end else begin
							d.m_sda = sending & ~q.sh[7]; // R04 R05
						end
					end
				end else if (tdone) begin
					d.m_scl = 1'b0;
					d.seen = 1'b0;
					d.mst = M_HIGH;
				end
			end
			M_HIGH: begin
				if (!q.seen) begin
					// a stretching party holds us here
					if (scl_s) begin
						d.seen = 1'b1; // R18
						d.tmr = HALF_CYC;
					end
				end else if (tdone) begin
					if ((q.cnt != `TW_ACK_IDX) & sending & ~q.m_sda & ~sda_s) begin
						d.lost = 1'b1; // R20
						d.m_sda = 1'b0;
						d.mst = M_LOST;
						d.rsp_v = 1'b1;
						d.rsp_d = q.sh;
						d.rsp_n = 1'b1;
					end else if (q.cnt != `TW_ACK_IDX) begin
						d.sh = {q.sh[6:0], sda_s}; // R05
						d.cnt = q.cnt + 4'h1;
						d.seen = 1'b0;
						d.m_scl = 1'b1;
						d.mst = M_LOW;
					end else begin
						d.nack = sending & sda_s; // R06
						d.rsp_v = 1'b1;
						d.rsp_d = q.sh;
						d.rsp_n = sda_s;
						d.apkt = 1'b0;
						d.m_scl = 1'b1; // R16
						d.mst = M_HOLD;
					end
				end
			end
			M_HOLD: begin
				d.m_scl = 1'b1; // R16
				if (cmd_take) begin
					case (cmd_kind)
						TW_CMD_START: begin
							d.sh = cmd_data; // R09
							d.rw = cmd_data[`TW_RW_BIT];
							d.apkt = 1'b1;
							d.nack = 1'b0;
							d.m_sda = 1'b0;
							d.tmr = HALF_CYC;
							d.mst = M_RS_A; // R03
						end
						TW_CMD_DATA: begin
							if (q.nack) begin
								d.m_sda = 1'b1; // R13 R14
								d.tmr = HALF_CYC;
								d.mst = M_ST_A;
							end else begin
								if (sending) begin
									d.sh = cmd_data; // R11
								end
								d.mack = cmd_ack; // R15
								d.cnt = 4'h0;
								d.seen = 1'b0;
								d.mst = M_LOW;
							end
						end
						default: begin
							d.m_sda = 1'b1; // R12
							d.tmr = HALF_CYC;
							d.mst = M_ST_A;
						end
					endcase
				end
			end
			M_RS_A: begin
				if (tdone) begin
					d.m_scl = 1'b0;
					d.seen = 1'b0;
					d.mst = M_RS_B;
				end
			end
			M_RS_B: begin
				if (!q.seen) begin
					if (scl_s) begin
						d.seen = 1'b1; // R18
						d.tmr = HALF_CYC;
					end
				end else if (tdone) begin
					d.m_sda = 1'b1; // R03
					d.tmr = HALF_CYC;
					d.mst = M_START;
				end
			end
			M_ST_A: begin
				if (tdone) begin
					d.m_scl = 1'b0;
					d.seen = 1'b0;
					d.mst = M_ST_B;
				end
			end
			M_ST_B: begin
				if (!q.seen) begin
					if (scl_s) begin
						d.seen = 1'b1;
						d.tmr = HALF_CYC;
					end
				end else if (tdone) begin
					d.m_sda = 1'b0; // R02
					d.tmr = HALF_CYC;
					d.mst = M_ST_C;
				end
			end
			M_ST_C: begin
				if (tdone) begin
					d.mst = M_IDLE;
				end
			end
			M_LOST: begin
				// lines released; no arbitration on start or stop phases
				d.m_scl = 1'b0;
				d.m_sda = 1'b0; // R22
				if (stop_ev) begin
					d.mst = M_IDLE; // R21
				end
			end
			default: begin
				d.mst = M_IDLE;
			end
		endcase

		// slave sequencer
		if (!slv_en) begin
			d.slv = S_IDLE;
			d.s_scl = 1'b0;
			d.s_sda = 1'b0;
		end else if (start_ev) begin
			d.slv = S_RX; // R03 R09
			d.scnt = 4'h0;
			d.sapkt = 1'b1;
			d.s_scl = 1'b0;
			d.s_sda = 1'b0;
		end else if (stop_ev) begin
			d.slv = S_IDLE; // R02
			d.s_scl = 1'b0;
			d.s_sda = 1'b0;
		end else begin
			case (q.slv)
				S_IDLE: begin
					d.s_scl = 1'b0;
					d.s_sda = 1'b0;
				end
				S_RX: begin
					if (scl_rise) begin
						d.ssh = {q.ssh[6:0], sda_s}; // R05
						d.scnt = q.scnt + 4'h1;
					end else if (scl_fall & (q.scnt == `TW_ACK_IDX)) begin
						if (q.sapkt & (q.ssh[7:1] != slv_addr)) begin
							d.slv = S_IDLE; // R08
						end else begin
							if (q.sapkt) begin
								d.srw = q.ssh[`TW_RW_BIT]; // R07
							end
							d.s_scl = 1'b1; // R16 R17
							d.sevt = 1'b1;
							d.sdat = q.ssh;
							d.sis_addr = q.sapkt;
							d.slv = S_WAIT;
						end
					end
				end
				S_WAIT: begin
					d.s_scl = 1'b1; // R17
					if (slv_go) begin
						if (q.sis_addr | ~q.srw) begin
							d.s_sda = slv_ack; // R06 R08
							d.sack = slv_ack;
							d.ssh = slv_tx_data;
							d.slv = S_ACK;
						end else begin
							d.ssh = slv_tx_data;
							d.s_sda = ~slv_tx_data[7];
							d.scnt = 4'h0;
							d.slv = S_TX;
						end
					end
				end
				S_ACK: begin
					// clock let go a cycle after the data settled
					d.s_scl = 1'b0; // R04
					if (scl_fall) begin
						d.sapkt = 1'b0;
						d.scnt = 4'h0;
						if (!q.sack) begin
							d.s_sda = 1'b0;
							d.slv = S_IDLE;
						end else if (q.srw & q.sis_addr) begin
							d.s_sda = ~q.ssh[7]; // R10
							d.slv = S_TX;
						end else begin
							d.s_sda = 1'b0; // R11
							d.slv = S_RX;
						end
					end
				end
				S_TX: begin
					d.s_scl = 1'b0;
					if (scl_fall) begin
						d.scnt = q.scnt + 4'h1;
						if (q.scnt == `TW_TX_LAST) begin
							d.s_sda = 1'b0;
							d.slv = S_MACK;
						end else begin
							d.ssh = {q.ssh[6:0], 1'b0};
							d.s_sda = ~q.ssh[6]; // R04 R05
						end
					end
				end
				S_MACK: begin
					if (scl_rise) begin
						d.sack = ~sda_s; // R06
					end else if (scl_fall) begin
						if (q.sack) begin
							d.s_scl = 1'b1; // R17
							d.sevt = 1'b1;
							d.sdat = q.ssh;
							d.sis_addr = 1'b0;
							d.slv = S_WAIT;
						end else begin
							d.slv = S_IDLE; // R15
						end
					end
				end
				default: begin
					d.slv = S_IDLE;
				end
			endcase
		end
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			q <= '0;
			q.scl_p <= 1'b1; // clock idles high: no false edge after reset
		end else begin
			q <= d;
		end
	end

	// outputs
	assign rsp_valid = q.rsp_v;
	assign rsp_data = q.rsp_d;
	assign rsp_nack = q.rsp_n;
	assign arb_lost = q.lost;
	assign bus_busy = q.busy;
	assign mst_active = (q.mst != M_IDLE);
	assign slv_evt = q.sevt;
	assign slv_is_addr = q.sis_addr;
	assign slv_rw = q.srw;
	assign slv_data = q.sdat;
endmodule // tw_engine
`default_nettype wire

// file: tb/tw_engine_properties.sv
/*
 checker on the engine's top ports: bus conditions, responses, arbitration.
 assumes: bound to every tw_engine by the bind at the foot.
*/
`timescale 1ns/1ps
`default_nettype none
module tw_engine_properties
	import tw_pkg::*;
#(
	parameter logic [15:0] HALF_CYC = 16'h0008
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// bus pins
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic scl_oe,
	input wire logic sda_oe,
	// master side
	input wire logic cmd_valid,
	input wire logic cmd_ready,
	input wire tw_cmd_e cmd_kind,
	input wire logic rsp_valid,
	input wire logic rsp_nack,
	input wire logic arb_lost,
	input wire logic bus_busy,
	input wire logic mst_active
);
	// ****
	// properties
	// ****
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// conditions seen on the pins, and a fresh start command taken
	sequence start_seen;
		scl_i && $past(scl_i) && $fell(sda_i);
	endsequence
	sequence stop_seen;
		scl_i && $past(scl_i) && $rose(sda_i);
	endsequence
	sequence start_taken;
		cmd_valid && cmd_ready && cmd_kind == TW_CMD_START && !mst_active;
	endsequence
	busy_on_start_a: assert property (start_seen |-> ##[1:10] bus_busy)
		else $error("bus busy missing after start");
	idle_on_stop_a: assert property (stop_seen |-> ##[1:10] !bus_busy)
		else $error("bus busy kept after stop");
	start_drive_a: assert property (start_taken |-> ##[1:4] (sda_oe && !scl_oe))
		else $error("start not driven with clock high");
	idle_start_a: assert property (start_taken |-> !bus_busy)
		else $error("start taken on busy bus");
	rsp_pulse_a: assert property (rsp_valid |=> !rsp_valid [*8])
		else $error("packet answers too close");
	lost_flags_a: assert property ($rose(arb_lost) |-> ##[0:1] rsp_nack)
		else $error("loss not reported as nack");
	lost_waits_a: assert property (arb_lost && bus_busy |-> !cmd_ready)
		else $error("ready while lost on busy bus");
	stretch_wait_a: assert property ((!scl_oe && !scl_i) [*2] |=> !scl_oe)
		else $error("clock pulled during peer stretch");
endmodule // tw_engine_properties
bind tw_engine tw_engine_properties #(.HALF_CYC(HALF_CYC)) tw_engine_properties_i (.sys_clk, .rst, .scl_i,
	.sda_i, .scl_oe, .sda_oe, .cmd_valid, .cmd_ready, .cmd_kind, .rsp_valid, .rsp_nack, .arb_lost, .bus_busy,
	.mst_active);
`default_nettype wire

// file: tb/tw_peer_slave.sv
/*
 behavioural peer slave on the bus: acks its address, takes writes,
 sends tx_byte on reads, stretches the clock before each ack.
 assumes: lines are wired-and with pull-ups in the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module tw_peer_slave #(
	parameter logic [6:0] ADDR = 7'h5A,
	parameter int STRETCH_NS = 2000
) (
	// bus lines
	input wire logic scl,
	input wire logic sda,
	output logic scl_low,
	output logic sda_low,
	// bench side
	input wire logic [7:0] tx_byte,
	output logic [7:0] rx_byte,
	output logic last_ack
);
	// ****
	// bit engine
	// ****
	int n;
	logic [7:0] sh;
	logic [7:0] tx;
	logic sel;
	logic rd;
	logic first;
	initial begin
		{scl_low, sda_low, sel, rd, first, last_ack} = '0;
		n = 0;
		sh = '0;
		tx = '0;
		rx_byte = '0;
	end
	// start restarts the packet count
	always @(negedge sda) begin
		if (scl === 1'h1) begin
			n = 0;
			first = 1;
			sel = 0;
		end
	end
	// stop releases everything
	always @(posedge sda) begin
		if (scl === 1'h1) begin
			n = 0;
			first = 0;
			sel = 0;
			sda_low = 0;
		end
	end
	// sample on the rising clock
	always @(posedge scl) begin
		if (n < 8) sh = {sh[6:0], sda};
		else last_ack = !sda;
		n = n + 1;
	end
	// data changes only with the clock low
	always @(negedge scl) begin
		if (n == 8) begin
			if (first) begin
				sel = (sh[7:1] == ADDR);
				rd = sh[0];
			end
			if (sel && !first && !rd) rx_byte = sh;
			sda_low = sel && (first || !rd);
			if (sel) begin
				scl_low = 1;
				#(STRETCH_NS) scl_low = 0;
			end
		end else if (n == 9) begin
			n = 0;
			sda_low = 0;
			if (sel && rd && (first || last_ack)) begin
				tx = tx_byte;
				sda_low = !tx[7];
			end else if (rd) sel = 0;
			first = 0;
		end else if (sel && rd && !first) sda_low = !tx[7 - n];
	end
endmodule // tw_peer_slave
`default_nettype wire

// file: tb/tb_top.sv
/*
 self-checking bench: engine as master against one peer slave and its own slave.
 assumes: logic/ files, checker and peer model compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import tw_pkg::*;
	// ****
	// clocks, bus and instances
	// ****
	logic sys_clk, link_clk, rst, cmd_valid, cmd_ack, jam, scl_oe, sda_oe, m_scl, m_sda;
	logic rsp_valid, rsp_nack, arb_lost, bus_busy, mst_active, cmd_ready, last_ack;
	logic slv_en, slv_go, slv_ack, slv_evt, slv_is_addr, slv_rw;
	logic [7:0] cmd_data, rsp_data, rx_byte, slv_data;
	tw_cmd_e cmd_kind;
	int mismatches, comparisons;
	wire logic scl;
	wire logic sda;
	// wired-and lines with pull-ups
	assign scl = !(scl_oe | m_scl);
	assign sda = !(sda_oe | m_sda | jam);
	initial begin
		sys_clk = 0;
		forever #20 sys_clk = !sys_clk;
	end
	initial begin
		link_clk = 0;
		#1.7;
		forever #3 link_clk = !link_clk;
	end
	tw_engine #(.HALF_CYC(16'h0008)) tw_engine_i (.sys_clk, .rst, .link_clk, .scl_i(scl), .scl_o(), .scl_oe,
		.sda_i(sda), .sda_o(), .sda_oe, .cmd_valid, .cmd_ready, .cmd_kind, .cmd_data, .cmd_ack, .rsp_valid,
		.rsp_data, .rsp_nack, .arb_lost, .bus_busy, .mst_active, .slv_en, .slv_addr(7'h33), .slv_evt,
		.slv_is_addr, .slv_rw, .slv_data, .slv_go, .slv_ack, .slv_tx_data(8'h00));
	tw_peer_slave tw_peer_slave_i (.scl, .sda, .scl_low(m_scl), .sda_low(m_sda), .tx_byte(8'hC3), .rx_byte,
		.last_ack);
	// ****
	// shared tasks
	// ****
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	// bounded wait: 0 answer, 1 ready, 2 idle, 3 lost, 4 clock low, 5 slave event
	task automatic wait_for(input int k);
		for (int i = 0; i < 6000; i++) begin
			@(posedge sys_clk);
			if (k == 0 ? rsp_valid === 1'h1 : k == 1 ? cmd_ready === 1'h1 : k == 2 ?
				(bus_busy === 1'h0 && mst_active === 1'h0) : k == 3 ? arb_lost === 1'h1 : k == 4 ? scl === 1'h0 :
				slv_evt === 1'h1) return;
		end
		chk("wait bound", 8'h00, 8'hFF);
		wrap_up();
	endtask
	task automatic send(input tw_cmd_e kind, input logic [7:0] data, input logic ack);
		@(posedge sys_clk);
		cmd_valid <= 1'h1;
		cmd_kind <= kind;
		cmd_data <= data;
		cmd_ack <= ack;
		wait_for(1);
		cmd_valid <= 1'h0;
		if (kind == TW_CMD_STOP) wait_for(2);
	endtask
	task automatic xfer(input tw_cmd_e kind, input logic [7:0] data, input logic ack);
		send(kind, data, ack);
		wait_for(0);
	endtask
	// ****
	// scenarios
	// ****
	task automatic t_arb;
		send(TW_CMD_START, 8'hB4, 1'h0);
		wait_for(4);
		jam <= 1'h1;
		wait_for(3);
		chk("lost nack", 8'h01, {7'h00, rsp_nack});
		chk("ready while lost", 8'h00, {7'h00, cmd_ready});
		jam <= 1'h0;
		wait_for(2);
		chk("ready after stop", 8'h01, {7'h00, cmd_ready});
		$display("test arbitration done");
	endtask
	task automatic t_write;
		xfer(TW_CMD_START, 8'hB4, 1'h0);
		chk("lost cleared", 8'h00, {7'h00, arb_lost});
		chk("addr ack", 8'h00, {7'h00, rsp_nack});
		chk("addr byte", 8'hB4, rsp_data);
		xfer(TW_CMD_DATA, 8'hA5, 1'h0);
		chk("data ack", 8'h00, {7'h00, rsp_nack});
		chk("peer byte", 8'hA5, rx_byte);
		send(TW_CMD_STOP, 8'h00, 1'h0);
		chk("busy after stop", 8'h00, {7'h00, bus_busy});
		$display("test write done");
	endtask
	task automatic t_nack;
		xfer(TW_CMD_START, 8'h22, 1'h0);
		chk("addr nack", 8'h01, {7'h00, rsp_nack});
		send(TW_CMD_DATA, 8'h55, 1'h0);
		wait_for(2);
		chk("busy after nack", 8'h00, {7'h00, bus_busy});
		xfer(TW_CMD_START, 8'hB4, 1'h0);
		send(TW_CMD_STOP, 8'h00, 1'h0);
		chk("no data moved", 8'hA5, rx_byte);
		$display("test nack done");
	endtask
	task automatic t_read;
		xfer(TW_CMD_START, 8'hB4, 1'h0);
		xfer(TW_CMD_START, 8'hB5, 1'h0);
		chk("busy kept", 8'h01, {7'h00, bus_busy});
		chk("read addr ack", 8'h00, {7'h00, rsp_nack});
		xfer(TW_CMD_DATA, 8'h00, 1'h1);
		chk("read byte 1", 8'hC3, rsp_data);
		chk("master ack", 8'h01, {7'h00, last_ack});
		xfer(TW_CMD_DATA, 8'h00, 1'h0);
		chk("read byte 2", 8'hC3, rsp_data);
		chk("master nack", 8'h00, {7'h00, last_ack});
		send(TW_CMD_STOP, 8'h00, 1'h0);
		$display("test read done");
	endtask
	// answer one own-slave event: release the stretch with an ack
	task automatic slv_answer;
		wait_for(5);
		slv_go <= 1'h1;
		slv_ack <= 1'h1;
		@(posedge sys_clk);
		slv_go <= 1'h0;
	endtask
	task automatic t_slave;
		slv_en <= 1'h1;
		fork
			xfer(TW_CMD_START, 8'h66, 1'h0);
			slv_answer();
		join
		chk("own addr ack", 8'h00, {7'h00, rsp_nack});
		chk("own addr byte", 8'h66, slv_data);
		chk("own addr flag", 8'h01, {7'h00, slv_is_addr});
		chk("own direction", 8'h00, {7'h00, slv_rw});
		fork
			xfer(TW_CMD_DATA, 8'h3C, 1'h0);
			slv_answer();
		join
		chk("own data ack", 8'h00, {7'h00, rsp_nack});
		chk("own data byte", 8'h3C, slv_data);
		chk("own data flag", 8'h00, {7'h00, slv_is_addr});
		send(TW_CMD_STOP, 8'h00, 1'h0);
		$display("test slave done");
	endtask
	// ****
	// main sequence
	// ****
	initial begin
		rst = 1'h1;
		cmd_valid = 1'h0;
		cmd_ack = 1'h0;
		jam = 1'h0;
		slv_en = 1'h0;
		slv_go = 1'h0;
		slv_ack = 1'h0;
		cmd_kind = TW_CMD_START;
		cmd_data = 8'h00;
		mismatches = 0;
		comparisons = 0;
		repeat (16) @(posedge sys_clk);
		rst <= 1'h0;
		repeat (4) @(posedge sys_clk);
		t_arb();
		t_write();
		t_nack();
		t_read();
		t_slave();
		wrap_up();
	end
endmodule // tb_top
`default_nettype wire
